//--- bench/adsr_host.sv
/* Host model: drives select and shift clock, samples the result.
   Assumes the readout top as the device on the link. */
`timescale 1ns/1ns
module adsr_host (
    input wire logic clk,
    output logic cs_n,
    output logic shift_clk,
    input wire logic dout,
    input wire logic dout_oe
);
    logic [31:0] got;
    logic [31:0] oe_got;
    logic oe_pre;

    // Idle: deselected, clock standing low
    initial
    begin
        cs_n = 1'b1;
        shift_clk = 1'b0;
    end

    // One 125 ns clock, sampled after its falling edge
    task automatic pulse(input int k);
        shift_clk = 1'b1;
        #62;
        shift_clk = 1'b0;
        #40;
        // Undriven pin reads as the inverse of the last level
        got[k] = dout_oe ? dout : ~dout;
        oe_got[k] = dout_oe;
        #23;
    endtask : pulse

    // Early clocks, then select low and n clocks
    task automatic frame(input int pre, input int n);
        int k;
        for (k = 0; k < pre; k++) pulse(31);
        got = '0;
        oe_got = '0;
        @(negedge clk);
        cs_n = 1'b0;
        #(adsr_pkg::WAKE_SETUP_NS);
        oe_pre = dout_oe;
        for (k = 0; k < n; k++) pulse(k);
    endtask : frame

    // End the exchange, give the core time to see it
    task automatic desel();
        @(negedge clk);
        cs_n = 1'b1;
        repeat (40) @(negedge clk);
    endtask : desel
endmodule : adsr_host

//--- bench/adsr_props.sv
/* Checker of the readout top ports.
   Assumes it is bound to adsr_readout. */
`timescale 1ns/1ns
module adsr_props #(
    parameter bit LOW_POWER = 1'b1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic shift_clk,
    input wire logic cs_n,
    input wire logic comp_in,
    input wire logic [11:0] dac_code,
    input wire logic sample_hold,
    input wire logic power_down,
    input wire logic dout,
    input wire logic dout_oe
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // Link side quiet while deselected
    a_desel_hiz: assert property (cs_n |-> !dout_oe)
        else $error("output enabled while deselected");
    a_desel_low: assert property (cs_n |-> !dout)
        else $error("data not low while deselected");
    // Driver waits for the first shift clock
    a_oe_wake: assert property ($fell(cs_n) |-> !dout_oe [*8])
        else $error("output enabled before first clock");
    a_oe_cause: assert property ($rose(dout_oe) |-> !cs_n && !shift_clk)
        else $error("output enabled without falling clock");
    a_dout_launch: assert property (!cs_n && $changed(dout) |-> !shift_clk)
        else $error("data changed outside falling clock");
    // Shutdown follows select
    a_pd_desel: assert property (cs_n [*4] |=> power_down == LOW_POWER)
        else $error("shutdown missing while deselected");
    a_pd_sel: assert property (!cs_n [*4] |=> !power_down)
        else $error("shutdown while selected");
    // Conversion starts in this exchange and takes twelve trials
    a_sample_win: assert property ($fell(cs_n) |-> ##[10:18] $rose(sample_hold))
        else $error("conversion not started after select");
    a_trial_msb: assert property ($rose(sample_hold) |-> dac_code == 12'h800)
        else $error("first trial code wrong");
    a_conv_len: assert property ($rose(sample_hold) |-> ##[44:52] $fell(sample_hold))
        else $error("conversion length wrong");

    // Main scenarios
    c_oe: cover property ($rose(dout_oe));
    c_conv: cover property ($fell(sample_hold));
    c_pd: cover property ($rose(power_down));
endmodule : adsr_props

//--- bench/tb_top.sv
/* Testbench of the serial result readout.
   Assumes the host model and an ideal comparator. */
`timescale 1ns/1ns
module tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [11:0] vin = 12'h000;
    logic comp_in;
    logic cs_n;
    logic shift_clk;
    logic [11:0] dac_code;
    logic sample_hold;
    logic power_down;
    logic dout;
    logic dout_oe;
    int miscompares = 0;
    int total_checks = 0;

    // Core clock
    always #2 clk = ~clk;
    // Comparator: high keeps the trial bit
    assign comp_in = (vin >= dac_code);

    adsr_readout #(.LOW_POWER(1'b1)) DUT (.clk(clk), .rst(rst), .shift_clk(shift_clk),
        .cs_n(cs_n), .comp_in(comp_in), .dac_code(dac_code), .sample_hold(sample_hold),
        .power_down(power_down), .dout(dout), .dout_oe(dout_oe));
    adsr_host host (.clk(clk), .cs_n(cs_n), .shift_clk(shift_clk), .dout(dout),
        .dout_oe(dout_oe));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Expected level after falling edge k
    function automatic logic exp_bit(input logic [11:0] v, input int k);
        if (k >= 3 && k <= 14)
            return v[14-k];
        if (k >= 15 && k <= 25)
            return v[k-14];
        return 1'b0;
    endfunction : exp_bit

    // Whole exchange and the low tail
    task automatic t_full();
        logic [31:0] e;
        int k;
        e = '0;
        vin = 12'ha5c;
        host.frame(0, 28);
        check(32'(host.oe_pre), 32'h0);
        check(host.oe_got, 32'h0fff_ffff);
        for (k = 1; k <= 28; k++) e[k-1] = exp_bit(vin, k);
        check(host.got, e);
        check(32'(power_down), 32'h0);
        host.desel();
        check(32'({dout_oe, dout, power_down}), 32'h1);
    endtask : t_full

    // Sixteen clocks read as two bytes
    task automatic two_bytes(input int pre, input logic [11:0] v);
        logic [15:0] w;
        int k;
        vin = v;
        host.frame(pre, 16);
        for (k = 0; k < 16; k++) w = {w[14:0], host.got[k]};
        host.desel();
        check(32'(w[15:8]), 32'({2'b00, v[11:6]}));
        check(32'(w[7:0]), 32'({v[5:0], v[1], v[2]}));
    endtask : two_bytes

    // Clocks before select are ignored
    task automatic t_prelude();
        two_bytes(2, 12'h0f3);
    endtask : t_prelude

    // Cut exchange, then a fresh one with a new value
    task automatic t_abort();
        vin = 12'hfff;
        host.frame(0, 6);
        check(32'(host.got[5:2]), 32'hf);
        host.desel();
        two_bytes(0, 12'h001);
    endtask : t_abort

    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_sim

    // Reset, then the scenarios
    initial
    begin
        repeat (16) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        repeat (8) @(negedge clk);
        t_full();
        t_prelude();
        t_abort();
        end_sim();
    end

    // Watchdog over a run of some 11 us
    initial
    begin
        #100000;
        miscompares++;
        end_sim();
    end
endmodule : tb_top

bind adsr_readout adsr_props #(.LOW_POWER(LOW_POWER)) props (.clk(clk), .rst(rst),
    .shift_clk(shift_clk), .cs_n(cs_n), .comp_in(comp_in), .dac_code(dac_code),
    .sample_hold(sample_hold), .power_down(power_down), .dout(dout), .dout_oe(dout_oe));

//--- design/adsr_readout.sv
/*
 * Top of the serial result readout: select and comparator
 * synchronisers, shutdown control, the conversion engine and the
 * shift-clock serialiser that drives the result pin.
 * Assumes a host that drives select low and pulses the shift clock,
 * and an external DAC and comparator around the dac_code output.
 */
`timescale 1ns/1ns

// Contract
// [R1] Three-wire synchronous half-duplex link
// [R2] Bits launched on falling shift clock
// [R3] No configuration word, no data input
// [R4] Single differential input, unipolar only
// [R5] Twelve-bit result, bit 11 down to 0
// [R6] Falling select starts an exchange
// [R7] Host waits wake setup before clocking
// [R8] Output disabled until first clock pulse
// [R9] Exactly one null bit before result
// [R10] MSB-first, then LSB-first repeat
// [R11] Data comes from this exchange's conversion
// [R12] Select high resets the sequencing
// [R13] Low-power variant shuts down while deselected
// [R14] First byte: enable, null, bits 11-6
// [R15] Second byte: bits 5-0, 1, 2
// [R16] Host may clock twice before select
// [R17] Host may bit-bang the three lines
// [R18] Shift clock ignored while deselected
// [R19] Output high impedance while deselected
// [R20] LSB-first repeat runs bit 1 to 11
// [R21] Output held low after last bit
module adsr_readout #(
    parameter bit LOW_POWER = 1'b1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic shift_clk,
    input wire logic cs_n,
    input wire logic comp_in,
    output logic [11:0] dac_code,
    output logic sample_hold,
    output logic power_down,
    output logic dout,
    output logic dout_oe
);
    adsr_pkg::adsr_core_s core_r;
    adsr_pkg::adsr_core_s core_nxt;
    adsr_pkg::adsr_link_s link_r;
    adsr_pkg::adsr_link_s link_nxt;
    logic link_rst;
    logic [4:0] slot_inc;
    logic [3:0] bit_idx;
    logic res_bit;

    adsr_conv_if conv_if ();

    // Conversion engine on the core clock
    adsr_sar u_sar (
        .clk(clk),
        .rst(rst),
        .conv(conv_if.eng)
    );

    // Core domain: synchronise select and comparator, find select edges
    always_comb
    begin
        core_nxt = core_r;
        core_nxt.cs_s1 = cs_n;
        core_nxt.cs_s2 = core_r.cs_s1;
        core_nxt.comp_s1 = comp_in;
        core_nxt.comp_s2 = core_r.comp_s1;
        core_nxt.cs_prev = core_r.cs_s2;
        // One-cycle start on the falling select
        core_nxt.start = core_r.cs_prev & ~core_r.cs_s2; // [R6]
        // Shutdown follows the deselected level
        core_nxt.power_down = LOW_POWER & core_r.cs_s2; // [R13]
    end

    // Core domain register
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            core_r <= adsr_pkg::CORE_RST;
        end
        else
        begin
            core_r <= core_nxt;
        end
    end

    // Engine control: start per exchange, drop result when deselected
    assign conv_if.start = core_r.start; // [R11]
    assign conv_if.abort = core_r.cs_s2; // [R12]
    assign conv_if.comp = core_r.comp_s2;

    // Select high holds the whole link side in reset
    assign link_rst = rst | cs_n; // [R12] [R18] [R16]

    // Saturating slot counter step
    assign slot_inc = (link_r.slot == adsr_pkg::SLOT_DONE) ? adsr_pkg::SLOT_DONE
        : 5'(link_r.slot + 5'h01);

    // Result bit index for the slot being launched
    always_comb
    begin
        bit_idx = 4'h0;
        if (slot_inc <= adsr_pkg::SLOT_MSB_LAST)
        begin
            // MSB-first: slot 3 gives bit 11, slot 14 gives bit 0
            bit_idx = 4'(adsr_pkg::SLOT_MSB_LAST - slot_inc); // [R10]
        end
        else
        begin
            // LSB-first repeat skips bit 0, slot 15 gives bit 1
            bit_idx = 4'(slot_inc - adsr_pkg::SLOT_MSB_LAST); // [R20]
        end
    end

    // Only a result flagged done in this exchange is shifted
    assign res_bit = link_r.done_s2 & conv_if.result[bit_idx]; // [R11] [R7]

    // Link domain: one slot per falling shift clock
    always_comb
    begin
        link_nxt = link_r;
        link_nxt.done_s1 = conv_if.done;
        link_nxt.done_s2 = link_r.done_s1;
        link_nxt.slot = slot_inc;
        // First pulse turns the driver on
        link_nxt.oe = 1'b1; // [R8] [R1]
        // Host data is never looked at; only the slot steers the pin
        unique case (1'b1) // [R3]
            (slot_inc == adsr_pkg::SLOT_ENABLE):
            begin
                link_nxt.dout = 1'b0; // [R14]
            end
            (slot_inc == adsr_pkg::SLOT_NULL):
            begin
                link_nxt.dout = 1'b0; // [R9]
            end
            (slot_inc >= adsr_pkg::SLOT_MSB_FIRST && slot_inc <= adsr_pkg::SLOT_LSB_LAST):
            begin
                link_nxt.dout = res_bit; // [R10] [R14] [R15]
            end
            default:
            begin
                link_nxt.dout = 1'b0; // [R21]
            end
        endcase
    end

    // Link register; falling edge launches each bit
    always_ff @(negedge shift_clk or posedge link_rst) // [R2]
    begin
        if (link_rst)
        begin
            // Driver off and sequence cleared while deselected
            link_r <= adsr_pkg::LINK_RST; // [R19] [R12]
        end
        else
        begin
            link_r <= link_nxt;
        end
    end

    // Outputs straight from flip-flops
    assign dout = link_r.dout; // [R1]
    assign dout_oe = link_r.oe; // [R19]
    assign power_down = core_r.power_down;
    assign dac_code = conv_if.dac_code;
    assign sample_hold = conv_if.hold;

endmodule : adsr_readout

//--- design/adsr_sar.sv
/*
 * Successive-approximation conversion engine on the core clock.
 * Assumes a synchronised comparator level and a one-cycle start pulse.
 */
`timescale 1ns/1ns
module adsr_sar (
    input wire logic clk,
    input wire logic rst,
    adsr_conv_if.eng conv
);
    adsr_pkg::adsr_sar_s s_r;
    adsr_pkg::adsr_sar_s s_nxt;

    // Sample, then one trial per result bit, MSB first
    always_comb
    begin
        s_nxt = s_r;
        if (conv.abort)
        begin
            s_nxt = adsr_pkg::SAR_RST;
        end
        else if (conv.start)
        begin
            s_nxt.st = adsr_pkg::ADSR_SAMPLE; // [R11]
            s_nxt.cnt = adsr_pkg::SAMPLE_LOAD;
            s_nxt.code = 12'h000;
            s_nxt.result = 12'h000;
            s_nxt.hold = 1'b0;
            s_nxt.done = 1'b0;
        end
        else
        begin
            unique case (s_r.st)
                adsr_pkg::ADSR_IDLE:
                begin
                    s_nxt.hold = 1'b0;
                end
                adsr_pkg::ADSR_SAMPLE:
                begin
                    if (s_r.cnt != 4'h0)
                    begin
                        s_nxt.cnt = s_r.cnt - 4'h1;
                    end
                    else
                    begin
                        // Fixed differential pair, unipolar code
                        s_nxt.hold = 1'b1; // [R4]
                        s_nxt.idx = adsr_pkg::RESULT_BIT_MSB; // [R5]
                        s_nxt.code = 12'h800;
                        s_nxt.cnt = adsr_pkg::SETTLE_LOAD;
                        s_nxt.st = adsr_pkg::ADSR_TRIAL;
                    end
                end
                adsr_pkg::ADSR_TRIAL:
                begin
                    if (s_r.cnt != 4'h0)
                    begin
                        s_nxt.cnt = s_r.cnt - 4'h1;
                    end
                    else
                    begin
                        // Keep the trial bit while input stays above DAC
                        s_nxt.code[s_r.idx] = conv.comp; // [R5]
                        s_nxt.cnt = adsr_pkg::SETTLE_LOAD;
                        if (s_r.idx == adsr_pkg::RESULT_BIT_LSB)
                        begin
                            s_nxt.result = s_nxt.code;
                            s_nxt.done = 1'b1;
                            s_nxt.hold = 1'b0;
                            s_nxt.st = adsr_pkg::ADSR_DONE;
                        end
                        else
                        begin
                            s_nxt.idx = s_r.idx - 4'h1;
                            s_nxt.code[s_r.idx - 4'h1] = 1'b1;
                        end
                    end
                end
                adsr_pkg::ADSR_DONE:
                begin
                    s_nxt.done = 1'b1;
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s_r <= adsr_pkg::SAR_RST;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign conv.dac_code = s_r.code;
    assign conv.hold = s_r.hold;
    assign conv.result = s_r.result;
    assign conv.done = s_r.done;

endmodule : adsr_sar

//--- shared/adsr_conv_if.sv
/*
 * Carrier between the readout top and its conversion engine.
 * Assumes all signals belong to the core clock domain.
 */
`timescale 1ns/1ns
interface adsr_conv_if;
    logic start;
    logic abort;
    logic comp;
    logic [11:0] dac_code;
    logic hold;
    logic [11:0] result;
    logic done;

    // Top side
    modport ctrl (
        output start,
        output abort,
        output comp,
        input dac_code,
        input hold,
        input result,
        input done
    );

    // Engine side
    modport eng (
        input start,
        input abort,
        input comp,
        output dac_code,
        output hold,
        output result,
        output done
    );
endinterface : adsr_conv_if

//--- shared/adsr_pkg.sv
/*
 * Constants and types of the serial result readout of a 12-bit
 * successive-approximation converter.
 * Assumes a 250 MHz core clock and a host-driven shift clock.
 */
package adsr_pkg;

    // Result format
    localparam int RES_BITS = 12;
    localparam logic [3:0] RESULT_BIT_MSB = 4'hb;
    localparam logic [3:0] RESULT_BIT_LSB = 4'h0;

    // Falling-edge slot numbers within one exchange
    localparam logic [4:0] SLOT_IDLE = 5'h00;
    localparam logic [4:0] SLOT_ENABLE = 5'h01;
    localparam logic [4:0] SLOT_NULL = 5'h02;
    localparam logic [4:0] SLOT_MSB_FIRST = 5'h03;
    localparam logic [4:0] SLOT_MSB_LAST = 5'h0e;
    localparam logic [4:0] SLOT_LSB_FIRST = 5'h0f;
    localparam logic [4:0] SLOT_LSB_LAST = 5'h19;
    localparam logic [4:0] SLOT_DONE = 5'h1a;

    // Timing in ns and derived core cycles
    localparam int CLK_PERIOD_NS = 4;
    localparam int SAMPLE_NS = 40;
    localparam int SETTLE_NS = 16;
    localparam int WAKE_SETUP_NS = 500;
    localparam int SAMPLE_CYC = (SAMPLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WAKE_SETUP_CYC = (WAKE_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] SAMPLE_LOAD = 4'(SAMPLE_CYC - 1);
    localparam logic [3:0] SETTLE_LOAD = 4'(SETTLE_CYC - 1);

    // Conversion engine states
    typedef enum logic [1:0] {
        ADSR_IDLE,
        ADSR_SAMPLE,
        ADSR_TRIAL,
        ADSR_DONE
    } adsr_conv_e;

    // Core-domain state of the top
    typedef struct packed {
        logic cs_s1;
        logic cs_s2;
        logic cs_prev;
        logic comp_s1;
        logic comp_s2;
        logic start;
        logic power_down;
    } adsr_core_s;

    // Link-domain state of the top
    typedef struct packed {
        logic [4:0] slot;
        logic done_s1;
        logic done_s2;
        logic dout;
        logic oe;
    } adsr_link_s;

    // Conversion engine state
    typedef struct packed {
        adsr_conv_e st;
        logic [3:0] cnt;
        logic [3:0] idx;
        logic [11:0] code;
        logic [11:0] result;
        logic hold;
        logic done;
    } adsr_sar_s;

    localparam adsr_core_s CORE_RST = '{cs_s1: 1'b1, cs_s2: 1'b1, cs_prev: 1'b1,
        comp_s1: 1'b0, comp_s2: 1'b0, start: 1'b0, power_down: 1'b0};
    localparam adsr_link_s LINK_RST = '{slot: 5'h00, done_s1: 1'b0, done_s2: 1'b0,
        dout: 1'b0, oe: 1'b0};
    localparam adsr_sar_s SAR_RST = '{st: ADSR_IDLE, cnt: 4'h0, idx: 4'h0,
        code: 12'h000, result: 12'h000, hold: 1'b0, done: 1'b0};

endpackage : adsr_pkg
